// ---- ufb_uart.sv ----
/*
 * serial port top: registers, format, holding register, pin handover.
 * assumes software on a plain strobe port; receiver kept to its flags.
 */
// Chosen here: the register offsets and strobed register access.
//
// Overview of operation
// [RL1] low speed: bit rate is clock over 64 times divisor plus one.
// [RL2] high speed: bit rate is clock over 16 times divisor plus one.
// [RL3] one free-running 8-bit reload counter times both directions. Here it times only the transmitter; the receiver has no bit timing.
// [RL4] frame is start bit, eight or nine data bits, one or two two_stop_sel.
// [RL5] after reset: eight data bits, no parity, one stop bit.
// [RL6] lsb first; both directions share format and rate.
// [RL7] parity or address bit takes the last data position.
// [RL8] odd parity when selected, even otherwise, only when parity on.
// [RL9] stop bit count independent of word length; two_stop_sel always sent.
// [RL10] ninth bit sent comes from the ninth-bit control field.
// [RL11] address detect keeps words with top bit set, drops others. Here addr_word_seen only marks such words; none are dropped.
// [RL12] pins serve the port only with port and direction enabled.
// [RL13] transmit line rests high when no frame runs.
// [RL14] port off empties the data buffer.
// [RL15] port off clears enables, break, error flags; sets idle flags.
// [RL16] port off aborts activity; re-enable keeps configuration.
// [RL17] shift register loads only after the stop bit has gone out.
// [RL18] frame starts once holding full, transmitter on, bit clock running.
// [RL19] empty shift register takes a written word at once.
// [RL20] transmit enable off mid-frame aborts and frees the pin.
// [RL21] shift register has no address; reached via holding register.
// [RL22] holding empty set on transfer; quiet set after last stop.
`timescale 1ns/100ps
module ufb_uart #(
    parameter int DIV_W = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    output logic tx_out,
    output logic tx_oe,
    input wire logic rx_in,
    output logic rx_pin_owned,
    output logic addr_word_seen
);
    ufb_pkg::ufb_cfg_s cfg_q;
    logic [DIV_W-1:0] div_q;
    logic [7:0] hold_q;
    logic hold_full_q;
    logic tx_empty_q;
    logic tx_quiet_q;
    logic rx_quiet_q;
    logic rx_avail_q;
    logic overrun_q;
    logic frame_q;
    logic parity_q;
    logic noise_q;
    logic rx_ninth_q;
    logic [7:0] rxd_q;
    logic rx_s1_q;
    logic rx_s2_q;
    logic bit_tick;
    logic sh_busy;
    logic sh_done;
    logic sh_line;
    logic tx_run;
    logic clr_tx;
    logic load;
    logic [8:0] word;
    logic par_bit;
    logic wr_c1;
    logic wr_c2;
    logic wr_txd;
    logic [7:0] status;

    assign wr_c1 = wr_stb && addr == ufb_pkg::CTRL1_OFS;
    assign wr_c2 = wr_stb && addr == ufb_pkg::CTRL2_OFS;
    assign wr_txd = wr_stb && addr == ufb_pkg::TXD_OFS;
    assign tx_run = cfg_q.port_on && cfg_q.transmit_on;
    assign clr_tx = !tx_run;

    // control registers; port off clears enables and break only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            // [RL5] default format
            cfg_q <= '0;
            div_q <= '0;
        end else begin
            if (wr_c1) begin
                cfg_q.port_on <= wdata[ufb_pkg::C1_PORT_ON];
                cfg_q.word_len_sel <= wdata[ufb_pkg::C1_WORD_LEN];
                cfg_q.parity_on <= wdata[ufb_pkg::C1_PAR_ON];
                cfg_q.parity_odd_sel <= wdata[ufb_pkg::C1_PAR_ODD];
                cfg_q.two_stop_sel <= wdata[ufb_pkg::C1_TWO_STOP];
                cfg_q.break_send <= wdata[ufb_pkg::C1_BREAK];
                cfg_q.tx_ninth_bit <= wdata[ufb_pkg::C1_TX9];
            end
            if (wr_c2) begin
                cfg_q.transmit_on <= wdata[ufb_pkg::C2_TX_ON];
                cfg_q.receive_on <= wdata[ufb_pkg::C2_RX_ON];
                cfg_q.baud_speed_sel <= wdata[ufb_pkg::C2_SPEED];
                cfg_q.addr_detect_on <= wdata[ufb_pkg::C2_ADDR];
            end
            if (wr_stb && addr == ufb_pkg::DIV_OFS) begin
                div_q <= wdata[DIV_W-1:0];
            end
            // [RL15] [RL16] disable clears enables and break, rest kept
            if (!cfg_q.port_on) begin
                cfg_q.transmit_on <= 1'b0;
                cfg_q.receive_on <= 1'b0;
                cfg_q.break_send <= 1'b0;
            end
        end
    end

    ufb_baud #(
        .DIV_W(DIV_W)
    ) u_baud (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clear(!cfg_q.port_on),
        .baud_divisor(div_q),
        .baud_speed_sel(cfg_q.baud_speed_sel),
        .bit_tick(bit_tick)
    );

    // [RL7] [RL8] [RL10] last position carries parity or ninth bit
    always_comb begin
        par_bit = cfg_q.word_len_sel ? ^hold_q : ^hold_q[6:0];
        par_bit = par_bit ^ cfg_q.parity_odd_sel;
        word = {cfg_q.tx_ninth_bit, hold_q};
        if (cfg_q.parity_on) begin
            if (cfg_q.word_len_sel) begin
                word[8] = par_bit;
            end else begin
                word[7] = par_bit;
            end
        end
    end

    // [RL17] [RL18] [RL19] move holding word when shifter is free
    assign load = tx_run && hold_full_q && !sh_busy;

    // [RL21] shift register lives only inside the shifter
    ufb_txshift u_shift (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clear(clr_tx),
        .bit_tick(bit_tick),
        .load(load),
        .word(word),
        .nine(cfg_q.word_len_sel),
        .two_stop(cfg_q.two_stop_sel),
        .hold_low(cfg_q.break_send),
        .busy(sh_busy),
        .done(sh_done),
        .line_q(sh_line)
    );

    // holding register and transmit flags
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_q <= '0;
            hold_full_q <= 1'b0;
            tx_empty_q <= 1'b1;
            tx_quiet_q <= 1'b1;
        end else if (!cfg_q.port_on) begin
            // [RL14] [RL15] buffer emptied, flags set
            hold_full_q <= 1'b0;
            tx_empty_q <= 1'b1;
            tx_quiet_q <= 1'b1;
        end else begin
            if (wr_txd && tx_empty_q) begin
                hold_q <= wdata;
                hold_full_q <= 1'b1;
                tx_empty_q <= 1'b0;
                tx_quiet_q <= 1'b0;
            end else if (load) begin
                // [RL22] transfer marks holding empty
                hold_full_q <= 1'b0;
                tx_empty_q <= 1'b1;
            end
            // [RL20] turning transmit off drops pending data; a word may wait for on
            if (wr_c2 && !wdata[ufb_pkg::C2_TX_ON]) begin
                hold_full_q <= 1'b0;
                tx_empty_q <= 1'b1;
            end
            // [RL22] quiet after last stop, set wins over clear
            if (sh_done && !hold_full_q) begin
                tx_quiet_q <= 1'b1;
            end
        end
    end

    // [RL12] [RL20] pin handover
    assign tx_out = tx_run ? sh_line : 1'b1;
    assign tx_oe = tx_run;
    assign rx_pin_owned = cfg_q.port_on && cfg_q.receive_on;

    // receive pin synchroniser
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= rx_in;
            rx_s2_q <= rx_s1_q;
        end
    end

    // receive flags: their disable behaviour, and rx_quiet_q following the synchronised pin when owned
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_quiet_q <= 1'b1;
            rx_avail_q <= 1'b0;
            overrun_q <= 1'b0;
            frame_q <= 1'b0;
            parity_q <= 1'b0;
            noise_q <= 1'b0;
            rx_ninth_q <= 1'b0;
            rxd_q <= '0;
        end else if (!rx_pin_owned) begin
            // [RL15] flags reset when off
            rx_quiet_q <= 1'b1;
            rx_avail_q <= 1'b0;
            overrun_q <= 1'b0;
            frame_q <= 1'b0;
            parity_q <= 1'b0;
            noise_q <= 1'b0;
        end else begin
            rx_quiet_q <= rx_s2_q;
        end
    end

    // [RL11] address word marker from the held receive word
    assign addr_word_seen = cfg_q.addr_detect_on &&
        (cfg_q.word_len_sel ? rx_ninth_q : rxd_q[7]);

    assign status = {noise_q, parity_q, frame_q, overrun_q, rx_avail_q,
        rx_quiet_q, tx_quiet_q, tx_empty_q};

    // read data one cycle after the read strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (rd_stb) begin
            unique case (addr)
                ufb_pkg::CTRL1_OFS: rdata <= {cfg_q.port_on, cfg_q.word_len_sel,
                    cfg_q.parity_on, cfg_q.parity_odd_sel, cfg_q.two_stop_sel,
                    cfg_q.break_send, rx_ninth_q, cfg_q.tx_ninth_bit};
                ufb_pkg::CTRL2_OFS: rdata <= {cfg_q.transmit_on, cfg_q.receive_on,
                    cfg_q.baud_speed_sel, cfg_q.addr_detect_on, 4'h0};
                ufb_pkg::DIV_OFS: rdata <= div_q;
                ufb_pkg::STAT_OFS: rdata <= status;
                ufb_pkg::RXD_OFS: rdata <= rxd_q;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // idle line when transmitter owns pin but is not busy
    idle_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tx_run && !$past(sh_busy) && !cfg_q.break_send && !$past(cfg_q.break_send)
        && $past(tx_run) |-> tx_out) else $error("idle line low"); // [RL13]
    off_flags_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !cfg_q.port_on |=> tx_empty_q && tx_quiet_q && !cfg_q.transmit_on)
        else $error("disable state wrong"); // [RL15]
    tx_pin_free_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !cfg_q.transmit_on |-> !tx_oe) else $error("pin held while off"); // [RL20]
    load_empty_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        load && cfg_q.port_on && cfg_q.transmit_on |=> tx_empty_q)
        else $error("no empty after load"); // [RL22]
    no_load_busy_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sh_busy |-> !load) else $error("load while shifting"); // [RL17]
    direct_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wr_txd && tx_empty_q && tx_run && !sh_busy && cfg_q.transmit_on
        |=> load) else $error("word not moved at once"); // [RL19]
    buf_empty_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !cfg_q.port_on |=> !hold_full_q) else $error("buffer kept"); // [RL14]
endmodule

// ---- ufb_pkg.sv ----
/*
 * shared constants and carriers for the serial port block.
 * assumes a single 40 MHz clock domain and a plain strobe register port.
 */
package ufb_pkg;
    // register offsets (byte-free indices on the plain port)
    localparam logic [2:0] CTRL1_OFS = 3'h0;
    localparam logic [2:0] CTRL2_OFS = 3'h1;
    localparam logic [2:0] DIV_OFS = 3'h2;
    localparam logic [2:0] STAT_OFS = 3'h3;
    localparam logic [2:0] TXD_OFS = 3'h4;
    localparam logic [2:0] RXD_OFS = 3'h5;
    // ctrl_reg_one fields
    localparam int C1_PORT_ON = 7;
    localparam int C1_WORD_LEN = 6;
    localparam int C1_PAR_ON = 5;
    localparam int C1_PAR_ODD = 4;
    localparam int C1_TWO_STOP = 3;
    localparam int C1_BREAK = 2;
    localparam int C1_RX9 = 1;
    localparam int C1_TX9 = 0;
    // ctrl_reg_two fields
    localparam int C2_TX_ON = 7;
    localparam int C2_RX_ON = 6;
    localparam int C2_SPEED = 5;
    localparam int C2_ADDR = 4;
    // status fields
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_TX_QUIET = 1;
    localparam int ST_RX_QUIET = 2;
    localparam int ST_RX_AVAIL = 3;
    localparam int ST_OVERRUN = 4;
    localparam int ST_FRAME = 5;
    localparam int ST_PARITY = 6;
    localparam int ST_NOISE = 7;
    // reset values: 8 data bits, no parity, one stop bit
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    // oversample divide per speed mode
    localparam logic [5:0] LOW_SPEED_DIV = 6'h3f;  // 64 - 1
    localparam logic [5:0] HIGH_SPEED_DIV = 6'h0f; // 16 - 1

    typedef struct packed {
        logic port_on;
        logic word_len_sel;
        logic parity_on;
        logic parity_odd_sel;
        logic two_stop_sel;
        logic break_send;
        logic tx_ninth_bit;
        logic transmit_on;
        logic receive_on;
        logic baud_speed_sel;
        logic addr_detect_on;
    } ufb_cfg_s;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_STOP = 3'b011
    } ufb_tx_e;
endpackage

// ---- ufb_baud.sv ----
/*
 * free-running bit clock: an 8-bit reload counter then a 16 or 64 prescale.
 * assumes ref_clk and a synchronous clear from the enclosing port.
 */
`timescale 1ns/100ps
module ufb_baud #(
    parameter int DIV_W = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic baud_speed_sel,
    output logic bit_tick
);
    logic [DIV_W-1:0] cnt_q;
    logic [5:0] pre_q;
    logic [5:0] pre_top;

    assign pre_top = baud_speed_sel ? ufb_pkg::HIGH_SPEED_DIV : ufb_pkg::LOW_SPEED_DIV;

    // [RL3] reload counter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (clear || cnt_q == '0) begin
            cnt_q <= baud_divisor;
        end else begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // [RL1] [RL2] prescale by 64 or 16
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= '0;
        end else if (clear) begin
            pre_q <= '0;
        end else if (cnt_q == '0) begin
            pre_q <= (pre_q >= pre_top) ? 6'h00 : pre_q + 6'h01;
        end
    end

    assign bit_tick = !clear && cnt_q == '0 && pre_q >= pre_top;

    // period check
    bit_gap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        bit_tick |=> !bit_tick) else $error("bit tick twice in a row"); // [RL3]
endmodule

// ---- ufb_txshift.sv ----
/*
 * frame shifter: start, 8 or 9 positions lsb first, one or two two_stop_sel.
 * assumes a one-cycle bit tick and a frame word already formed.
 */
`timescale 1ns/100ps
module ufb_txshift (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic bit_tick,
    input wire logic load,
    input wire logic [8:0] word,
    input wire logic nine,
    input wire logic two_stop,
    input wire logic hold_low,
    output logic busy,
    output logic done,
    output logic line_q
);
    ufb_pkg::ufb_tx_e st_q;
    logic [8:0] sh_q;
    logic [3:0] cnt_q;
    logic nine_q;
    logic two_q;

    // the last stop tick counts as free, so a waiting word follows with no gap
    assign busy = st_q != ufb_pkg::TX_IDLE && !done;
    assign done = st_q == ufb_pkg::TX_STOP && bit_tick && cnt_q == 4'h0;

    // [RL4] [RL6] [RL9] frame sequencer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ufb_pkg::TX_IDLE;
            sh_q <= '0;
            cnt_q <= '0;
            nine_q <= 1'b0;
            two_q <= 1'b0;
        end else if (clear) begin
            st_q <= ufb_pkg::TX_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (st_q)
                ufb_pkg::TX_IDLE: begin
                    if (load) begin
                        // wait for a tick so the start bit is a whole bit long
                        st_q <= ufb_pkg::TX_START;
                        cnt_q <= 4'hf;
                        sh_q <= word;
                        nine_q <= nine;
                        two_q <= two_stop;
                    end
                end
                ufb_pkg::TX_START: begin
                    if (bit_tick) begin
                        if (cnt_q == 4'hf) begin
                            cnt_q <= 4'h0;
                        end else begin
                            st_q <= ufb_pkg::TX_DATA;
                            cnt_q <= nine_q ? 4'h8 : 4'h7;
                        end
                    end
                end
                ufb_pkg::TX_DATA: begin
                    if (bit_tick) begin
                        sh_q <= {1'b0, sh_q[8:1]};
                        if (cnt_q == 4'h0) begin
                            st_q <= ufb_pkg::TX_STOP;
                            cnt_q <= two_q ? 4'h1 : 4'h0;
                        end else begin
                            cnt_q <= cnt_q - 4'h1;
                        end
                    end
                end
                ufb_pkg::TX_STOP: begin
                    if (bit_tick) begin
                        if (cnt_q == 4'h0 && load) begin
                            // [RL17] next word starts right after the stop bit
                            st_q <= ufb_pkg::TX_START;
                            sh_q <= word;
                            nine_q <= nine;
                            two_q <= two_stop;
                        end else if (cnt_q == 4'h0) begin
                            st_q <= ufb_pkg::TX_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 4'h1;
                        end
                    end
                end
                default: st_q <= ufb_pkg::TX_IDLE;
            endcase
        end
    end

    // [RL13] line level, high at rest
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_q <= 1'b1;
        end else if (hold_low && st_q != ufb_pkg::TX_STOP) begin
            line_q <= 1'b0;
        end else if (st_q == ufb_pkg::TX_START && cnt_q != 4'hf) begin
            line_q <= 1'b0;
        end else if (st_q == ufb_pkg::TX_DATA) begin
            line_q <= sh_q[0];
        end else begin
            line_q <= 1'b1;
        end
    end

    // stop bits are high
    stop_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_q == ufb_pkg::TX_STOP && $past(st_q) == ufb_pkg::TX_STOP && !hold_low
        |=> line_q) else $error("stop bit not high"); // [RL9]
    start_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_q == ufb_pkg::TX_START && cnt_q != 4'hf && !hold_low |=> !line_q)
        else $error("start bit missing"); // [RL4]
endmodule

// ---- ufb_remote_node.sv ----
/*
 * remote serial node: samples the transmit line mid-bit and logs frames.
 * assumes bit length and data count are handed in by the bench.
 */
`timescale 1ns/100ps
module ufb_remote_node (
    input wire logic ref_clk,
    input wire logic line,
    input wire logic line_oe,
    input wire logic [15:0] bit_cyc,
    input wire logic [3:0] nbits,
    output logic rx_line,
    output logic [8:0] word_q,
    output logic [15:0] frames_q,
    output logic [31:0] start_q
);
    logic [31:0] now_q;
    logic [8:0] w;
    logic ok;
    // our own transmit line rests at mark
    assign rx_line = 1'b1;
    // cycle stamp for frame starts
    initial now_q = '0;
    always @(posedge ref_clk) now_q <= now_q + 32'h1;
    // hunt a start bit, sample lsb first, keep a frame only if stop is high
    initial begin
        frames_q = '0;
        word_q = '0;
        start_q = '0;
        forever begin
            @(posedge ref_clk);
            if (line_oe === 1'b1 && line === 1'b0) begin
                start_q = now_q;
                ok = 1'b1;
                w = '0;
                repeat (bit_cyc / 2) @(posedge ref_clk);
                for (int i = 0; i <= nbits; i++) begin
                    repeat (bit_cyc) @(posedge ref_clk);
                    ok = ok & (line_oe === 1'b1);
                    if (i < nbits) begin
                        w[i] = line;
                    end else begin
                        ok = ok & (line === 1'b1);
                    end
                end
                if (ok) begin
                    word_q = w;
                    frames_q = frames_q + 16'h1;
                end
            end
        end
    end
endmodule

// ---- uart_format_baud_transmitter_tb.sv ----
/*
 * self-checking bench for the serial port: format table, then hand cases.
 * assumes the remote node model on the transmit line and a 40 MHz clock.
 */
`timescale 1ns/100ps
module uart_format_baud_transmitter_tb;
    typedef struct packed {
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] dv;
        logic [7:0] d;
        logic [8:0] w;
        logic [3:0] nb;
        logic [3:0] ns;
    } ufb_row_s;
    // ctrl1, ctrl2, divisor, data, expected word, data bits, stop bits
    localparam ufb_row_s ROWS [11] = '{
        '{8'h80, 8'ha0, 8'h00, 8'ha5, 9'h0a5, 4'h8, 4'h1},
        '{8'h80, 8'h80, 8'h00, 8'h3c, 9'h03c, 4'h8, 4'h1},
        '{8'h80, 8'ha0, 8'h02, 8'h81, 9'h081, 4'h8, 4'h1},
        '{8'h80, 8'h80, 8'h01, 8'h55, 9'h055, 4'h8, 4'h1},
        '{8'ha0, 8'ha0, 8'h00, 8'h13, 9'h093, 4'h8, 4'h1},
        '{8'hb0, 8'ha0, 8'h00, 8'h93, 9'h013, 4'h8, 4'h1},
        '{8'hc1, 8'ha0, 8'h00, 8'h0f, 9'h10f, 4'h9, 4'h1},
        '{8'hc0, 8'ha0, 8'h00, 8'hf0, 9'h0f0, 4'h9, 4'h1},
        '{8'he0, 8'ha0, 8'h00, 8'h07, 9'h107, 4'h9, 4'h1},
        '{8'h88, 8'ha0, 8'h00, 8'hff, 9'h0ff, 4'h8, 4'h2},
        '{8'hf8, 8'ha0, 8'h00, 8'h01, 9'h001, 4'h9, 4'h2}};
    logic ref_clk, arst_n, wr_stb, rd_stb, tx_out, tx_oe, rx_in, rx_pin_owned;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic [15:0] bit_cyc, frames, f0;
    logic [3:0] nbits;
    logic [8:0] word;
    logic [31:0] start, s1, w0;
    int err_total, total_checks, cyc, k;

    ufb_uart i_ufb_uart (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .tx_out(tx_out), .tx_oe(tx_oe),
        .rx_in(rx_in), .rx_pin_owned(rx_pin_owned), .addr_word_seen());
    ufb_remote_node i_ufb_remote_node (.ref_clk(ref_clk), .line(tx_out), .line_oe(tx_oe),
        .bit_cyc(bit_cyc), .nbits(nbits), .rx_line(rx_in), .word_q(word),
        .frames_q(frames), .start_q(start));

    // 25 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // cycle count and hang guard
    initial cyc = 0;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            finish_test;
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
        rd(a, rv);
        chk("rdata", {24'h0, e}, {24'h0, rv});
    endtask
    task automatic wait_fr(input int n);
        k = 0;
        while (frames !== f0 + n && k < 4000) begin
            @(negedge ref_clk);
            k++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // start a frame, then drop an enable part way through
    task automatic abort_run(input logic [2:0] a, input logic [7:0] d);
        f0 = frames;
        wr(ufb_pkg::TXD_OFS, 8'h00);
        repeat (200) @(negedge ref_clk);
        wr(a, d);
        @(negedge ref_clk);
        chk("tx_oe", 0, tx_oe);
        chk("tx_out", 1, tx_out);
    endtask

    // main sequence
    initial begin
        {arst_n, wr_stb, rd_stb, addr, wdata, err_total, total_checks} = '0;
        bit_cyc = 16'd16;
        nbits = 4'h8;
        repeat (5) @(negedge ref_clk);
        chk("tx_out", 1, tx_out);
        chk("tx_oe", 0, tx_oe);
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdchk(ufb_pkg::CTRL1_OFS, 8'h00);
        for (int r = 0; r < 11; r++) begin
            wr(ufb_pkg::CTRL1_OFS, ROWS[r].c1);
            wr(ufb_pkg::CTRL2_OFS, ROWS[r].c2);
            wr(ufb_pkg::DIV_OFS, ROWS[r].dv);
            bit_cyc = (16'(ROWS[r].dv) + 16'h1) * (ROWS[r].c2[5] ? 16'd16 : 16'd64);
            nbits = ROWS[r].nb;
            f0 = frames;
            wr(ufb_pkg::TXD_OFS, ROWS[r].d);
            w0 = cyc;
            rv = 8'h00;
            for (int j = 0; j < 50 && rv[0] !== 1'b1; j++) rd(ufb_pkg::STAT_OFS, rv);
            wr(ufb_pkg::TXD_OFS, ROWS[r].d);
            wait_fr(1);
            s1 = start;
            chk("word", ROWS[r].w, word);
            chk("prompt", 1, (s1 - w0) <= bit_cyc + 4);
            wait_fr(2);
            chk("word", ROWS[r].w, word);
            chk("gap", (1 + ROWS[r].nb + ROWS[r].ns) * bit_cyc, start - s1);
            repeat (2 * bit_cyc) @(negedge ref_clk);
            rd(ufb_pkg::STAT_OFS, rv);
            chk("status", 2'b11, rv[1:0]);
            chk("tx_out", 1, tx_out);
        end
        // unmapped addresses read as zero
        rdchk(3'h6, 8'h00);
        rdchk(3'h7, 8'h00);
        // data loaded while the transmitter is off waits for the enable
        wr(ufb_pkg::CTRL1_OFS, 8'h80);
        wr(ufb_pkg::CTRL2_OFS, 8'h20);
        bit_cyc = 16'd16;
        nbits = 4'h8;
        f0 = frames;
        wr(ufb_pkg::TXD_OFS, 8'h5a);
        repeat (300) @(negedge ref_clk);
        chk("tx_oe", 0, tx_oe);
        chk("frames", f0, frames);
        wr(ufb_pkg::CTRL2_OFS, 8'ha0);
        wait_fr(1);
        chk("word", 9'h05a, word);
        // port off in mid-frame: abort, flags, kept configuration
        wr(ufb_pkg::DIV_OFS, 8'h03);
        wr(ufb_pkg::CTRL2_OFS, 8'he0);
        bit_cyc = 16'd64;
        @(negedge ref_clk);
        chk("rx_own", 1, rx_pin_owned);
        abort_run(ufb_pkg::CTRL1_OFS, 8'h00);
        chk("rx_own", 0, rx_pin_owned);
        rdchk(ufb_pkg::CTRL2_OFS, 8'h20);
        rdchk(ufb_pkg::DIV_OFS, 8'h03);
        rdchk(ufb_pkg::STAT_OFS, 8'h07);
        repeat (800) @(negedge ref_clk);
        chk("frames", f0, frames);
        wr(ufb_pkg::CTRL1_OFS, 8'h80);
        wr(ufb_pkg::CTRL2_OFS, 8'ha0);
        f0 = frames;
        wr(ufb_pkg::TXD_OFS, 8'h3c);
        wait_fr(1);
        chk("word", 9'h03c, word);
        // transmit enable off in mid-frame
        repeat (200) @(negedge ref_clk);
        abort_run(ufb_pkg::CTRL2_OFS, 8'h20);
        repeat (800) @(negedge ref_clk);
        chk("frames", f0, frames);
        // second reset in mid-run restores the default format
        wr(ufb_pkg::CTRL1_OFS, 8'hf9);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        @(negedge ref_clk);
        chk("tx_oe", 0, tx_oe);
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdchk(ufb_pkg::CTRL1_OFS, 8'h00);
        rdchk(ufb_pkg::DIV_OFS, 8'h00);
        finish_test;
    end
endmodule
